// ==== common/mc_router_pkg.sv ====
// Purpose : constants and types shared by the multicast ingress router
// Assumes : 32-bit register port, byte addresses, one register per aligned word
// Notes   : per-port register blocks repeat at a fixed stride above the global ones
package mc_router_pkg;

  // ********************************************************************
  // register port
  // ********************************************************************
  localparam int          REG_ADDR_W      = 12;        // byte address width
  localparam int          REG_DATA_W      = 32;        // data width
  localparam logic [11:0] OFS_PART_CTL    = 12'h000;   // multicast_control_reg
  localparam logic [11:0] OFS_CAP         = 12'h004;   // multicast_capability_reg
  localparam logic [11:0] OFS_BASE_LO     = 12'h008;   // group_base_low + index position
  localparam logic [11:0] OFS_BASE_HI     = 12'h00c;   // group_base_high
  localparam logic [11:0] OFS_LOG_LO      = 12'h010;   // logged header address, low
  localparam logic [11:0] OFS_LOG_HI      = 12'h014;   // logged header address, high
  localparam logic [11:0] OFS_PORT_BASE   = 12'h100;   // first per-port block
  localparam int          PORT_STRIDE_LOG = 5;         // 32 bytes per port block
  // offsets inside one port block
  localparam logic [4:0]  OFS_P_CTL       = 5'h00;     // function enable, upstream flag
  localparam logic [4:0]  OFS_P_RCV_LO    = 5'h04;     // receive_vector_low_reg
  localparam logic [4:0]  OFS_P_RCV_HI    = 5'h08;     // receive_vector_high_reg
  localparam logic [4:0]  OFS_P_BLK_LO    = 5'h0c;     // block_all_low_reg
  localparam logic [4:0]  OFS_P_BLK_HI    = 5'h10;     // block_all_high_reg
  localparam logic [4:0]  OFS_P_BUT_LO    = 5'h14;     // block_untranslated_low_reg
  localparam logic [4:0]  OFS_P_BUT_HI    = 5'h18;     // block_untranslated_high_reg
  localparam logic [4:0]  OFS_P_STS       = 5'h1c;     // primary/secondary status flags

  // ********************************************************************
  // field positions and reset values
  // ********************************************************************
  localparam int          POS_PART_EN     = 0;         // partition_multicast_enable
  localparam int          POS_NUMGRP      = 8;         // enabled_group_count, 6 bits
  localparam int          POS_MAXGRP      = 0;         // max_group_count, 6 bits
  localparam int          POS_INDEX       = 0;         // region_index_position, 6 bits
  localparam int          POS_BASE_LO     = 12;        // base bits 31:12
  localparam int          POS_FN_EN       = 0;         // function_multicast_enable
  localparam int          POS_UPSTREAM    = 1;         // port faces upstream
  localparam int          POS_STA_PRI     = 0;         // flag in primary_status_reg
  localparam int          POS_STA_SEC     = 1;         // flag in secondary_status_reg
  localparam logic [5:0]  RST_MAXGRP      = 6'h1f;     // 32 groups advertised
  localparam logic [1:0]  AT_UNTRANSLATED = 2'h0;      // address type, untranslated
  localparam int          GROUP_MAX       = 64;        // hard ceiling on groups

  // ********************************************************************
  // packet kinds offered at ingress
  // ********************************************************************
  typedef enum logic [1:0] {
    KIND_MEM_WRITE = 2'h0,   // posted memory write
    KIND_ADDR_MSG  = 2'h1,   // address-routed message
    KIND_OTHER     = 2'h2    // anything else
  } pkt_kind_t;

endpackage

// ==== rtl/mc_router.sv ====
// Purpose : ingress multicast classification, blocking and virtual-bus routing
// Assumes : one header per PKT_VALID cycle from the receive paths, single clock
// Notes   : one-stage pipeline, results one cycle after the header, never stalls
`timescale 1ns/1ps

module mc_router #(
  parameter int NUM_PORTS = 16                    // switch ports in the partition
) (
  input  wire logic                                 SYS_CLK,
  input  wire logic                                 RESETN,
  input  wire logic [mc_router_pkg::REG_ADDR_W-1:0] REG_ADDR,
  input  wire logic [mc_router_pkg::REG_DATA_W-1:0] REG_WDATA,
  input  wire logic                                 REG_WR,
  input  wire logic                                 REG_RD,
  output logic      [mc_router_pkg::REG_DATA_W-1:0] REG_RDATA,
  input  wire logic                                 PKT_VALID,
  input  wire mc_router_pkg::pkt_kind_t             PKT_KIND,
  input  wire logic [63:0]                          PKT_ADDR,
  input  wire logic [1:0]                           PKT_AT,
  input  wire logic [$clog2(NUM_PORTS)-1:0]         PKT_PORT,
  input  wire logic                                 PKT_ERR,
  input  wire logic                                 PKT_ACS_FAIL,
  output logic                                      RES_VALID,
  output logic                                      RES_UNICAST,
  output logic                                      RES_MULTICAST,
  output logic      [5:0]                           RES_GROUP,
  output logic      [NUM_PORTS-1:0]                 RES_ACCEPT,
  output logic                                      RES_DISCARD,
  output logic                                      RES_ACS_FAIL,
  output logic                                      RES_BLOCKED,
  output logic                                      RES_CREDIT_RETURN,
  output logic                                      RES_AER_MC_BLOCKED,
  output logic                                      RES_PASS_ERR
);
  import mc_router_pkg::*;

  localparam int PW = $clog2(NUM_PORTS);

  // ********************************************************************
  // elaboration checks
  // ********************************************************************
  // the per-port blocks must fit below the top of the register space
  if (NUM_PORTS < 2 || NUM_PORTS > 24) begin : g_bad_ports
    $error("NUM_PORTS must lie between 2 and 24");
  end

  // ********************************************************************
  // functions
  // ********************************************************************
  // width of the group field for a given encoded count (count = groups-1)
  function automatic logic [2:0] gid_width(input logic [5:0] count);
    logic [6:0] groups;
    logic [2:0] w;
    groups = {1'b0, count} + 7'h01;
    w      = 3'h0;
    for (int i = 0; i < 7; i++) begin
      if ((7'h01 << i) < groups) w = 3'(i + 1);
    end
    return w;
  endfunction

  // look up one group's bit in a 64-bit per-group vector
  function automatic logic group_bit(input logic [63:0] vec, input logic [5:0] gid);
    return vec[gid];
  endfunction

  // ********************************************************************
  // register state
  // ********************************************************************
  logic             part_en;                   // partition_multicast_enable
  logic [5:0]       numgrp;                    // enabled_group_count
  logic [5:0]       maxgrp;                    // max_group_count
  logic [5:0]       index_pos;                 // region_index_position
  logic [63:0]      base;                      // assembled group base
  logic [63:0]      log_addr;                  // last blocked header address
  logic [NUM_PORTS-1:0] fn_en;                 // function_multicast_enable per port
  logic [NUM_PORTS-1:0] upstream;              // port role
  logic [NUM_PORTS-1:0] sta_pri;               // signaled abort, primary status
  logic [NUM_PORTS-1:0] sta_sec;               // signaled abort, secondary status
  logic [63:0]      rcv_vec [NUM_PORTS];       // receive_vector per port
  logic [63:0]      blk_vec [NUM_PORTS];       // block_all_vector per port
  logic [63:0]      but_vec [NUM_PORTS];       // block_untranslated_vector per port
  logic [REG_DATA_W-1:0] rdata;                // read answer register

  logic             next_part_en;
  logic [5:0]       next_numgrp;
  logic [5:0]       next_maxgrp;
  logic [5:0]       next_index_pos;
  logic [63:0]      next_base;
  logic [63:0]      next_log_addr;
  logic [NUM_PORTS-1:0] next_fn_en;
  logic [NUM_PORTS-1:0] next_upstream;
  logic [NUM_PORTS-1:0] next_sta_pri;
  logic [NUM_PORTS-1:0] next_sta_sec;
  logic [63:0]      next_rcv_vec [NUM_PORTS];
  logic [63:0]      next_blk_vec [NUM_PORTS];
  logic [63:0]      next_but_vec [NUM_PORTS];
  logic [REG_DATA_W-1:0] next_rdata;

  // ********************************************************************
  // classification (combinational, one header per cycle)
  // ********************************************************************
  logic [2:0]       gw;                        // group field width
  logic [63:0]      low_mask;                  // bits below the index position
  logic [63:0]      grp_mask;                  // group field bits
  logic [5:0]       gid;                       // extracted group
  logic             candidate;                 // type qualifies
  logic             is_mc;                     // classified multicast
  logic             blocked;                   // blocked at ingress
  logic [NUM_PORTS-1:0] accept;                // functions taking the packet

  // address decode and group extraction in one cone
  always_comb begin
    logic [63:0] shifted;
    shifted   = 64'h0;
    gw        = gid_width(numgrp);
    low_mask  = (64'h1 << index_pos) - 64'h1;
    grp_mask  = ((64'h1 << gw) - 64'h1) << index_pos;
    shifted   = PKT_ADDR >> index_pos;
    gid       = shifted[5:0] & 6'((7'h01 << gw) - 7'h01);
    candidate = (PKT_KIND == KIND_MEM_WRITE) || (PKT_KIND == KIND_ADDR_MSG);
    // disabled partition or mismatch falls back to unicast
    is_mc     = part_en && candidate
                && ((PKT_ADDR & ~(low_mask | grp_mask)) == base)
                && (gid <= numgrp);
    // ingress blocking uses the vectors of the receiving port
    blocked   = group_bit(blk_vec[PKT_PORT], gid)
                || (group_bit(but_vec[PKT_PORT], gid)
                    && (PKT_AT == AT_UNTRANSLATED));
    // virtual-bus fan-out: every other enabled member takes it
    for (int p = 0; p < NUM_PORTS; p++) begin
      accept[p] = fn_en[p] && group_bit(rcv_vec[p], gid)
                  && (PW'(p) != PKT_PORT);
    end
  end

  // ********************************************************************
  // result stage
  // ********************************************************************
  logic                 res_valid, next_res_valid;
  logic                 res_uni, next_res_uni;
  logic                 res_mc, next_res_mc;
  logic [5:0]           res_gid, next_res_gid;
  logic [NUM_PORTS-1:0] res_acc, next_res_acc;
  logic                 res_disc, next_res_disc;
  logic                 res_acs, next_res_acs;
  logic                 res_blk, next_res_blk;
  logic                 res_err, next_res_err;

  // decide the fate of the header offered this cycle
  always_comb begin
    next_res_valid = PKT_VALID;             // one result per header, in order
    next_res_uni   = 1'b0;
    next_res_mc    = 1'b0;
    next_res_gid   = 6'h0;
    next_res_acc   = '0;
    next_res_disc  = 1'b0;
    next_res_acs   = 1'b0;
    next_res_blk   = 1'b0;
    next_res_err   = 1'b0;
    if (PKT_VALID) begin
      if (PKT_ERR) begin
        // common checks already failed: passed with the error flag, not classified
        next_res_err = 1'b1;
      end else if (!is_mc) begin
        next_res_uni = 1'b1;
      end else begin
        next_res_mc  = 1'b1;
        next_res_gid = gid;
        if (PKT_ACS_FAIL) begin
          // source validation is the only access check on multicast
          next_res_acs = 1'b1;
        end else if (blocked) begin
          next_res_blk = 1'b1;
        end else if (accept == '0) begin
          next_res_disc = 1'b1;
        end else begin
          // handed to egress processing of each acceptor
          next_res_acc = accept;
        end
      end
    end
  end

  // result registers
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      res_valid <= 1'b0;
      res_uni   <= 1'b0;
      res_mc    <= 1'b0;
      res_gid   <= 6'h0;
      res_acc   <= '0;
      res_disc  <= 1'b0;
      res_acs   <= 1'b0;
      res_blk   <= 1'b0;
      res_err   <= 1'b0;
    end else begin
      res_valid <= next_res_valid;
      res_uni   <= next_res_uni;
      res_mc    <= next_res_mc;
      res_gid   <= next_res_gid;
      res_acc   <= next_res_acc;
      res_disc  <= next_res_disc;
      res_acs   <= next_res_acs;
      res_blk   <= next_res_blk;
      res_err   <= next_res_err;
    end
  end

  assign RES_VALID          = res_valid;
  assign RES_UNICAST        = res_uni;
  assign RES_MULTICAST      = res_mc;
  assign RES_GROUP          = res_gid;
  assign RES_ACCEPT         = res_acc;
  assign RES_DISCARD        = res_disc;
  assign RES_ACS_FAIL       = res_acs;
  assign RES_BLOCKED        = res_blk;
  assign RES_CREDIT_RETURN  = res_blk;     // dropped yet credited
  assign RES_AER_MC_BLOCKED = res_blk;     // reported with logged header
  assign RES_PASS_ERR       = res_err;
  assign REG_RDATA          = rdata;

  // ********************************************************************
  // register file: writes, flag setting and read answer
  // ********************************************************************
  logic                 blk_event;         // a block decided this cycle
  logic                 port_hit;          // address lies in a port block
  logic [PW-1:0]        port_sel;          // addressed port
  logic [4:0]           port_ofs;          // offset inside that block
  logic [REG_ADDR_W-1:0] port_rel;         // address relative to the first block

  always_comb begin
    blk_event = PKT_VALID && !PKT_ERR && is_mc && !PKT_ACS_FAIL && blocked;
    port_rel  = REG_ADDR - OFS_PORT_BASE;
    port_hit  = (REG_ADDR >= OFS_PORT_BASE)
                && ((port_rel >> PORT_STRIDE_LOG) < REG_ADDR_W'(NUM_PORTS));
    port_sel  = PW'(port_rel >> PORT_STRIDE_LOG);
    port_ofs  = port_rel[4:0];
  end

  // next register values; hardware set beats a same-cycle clear
  always_comb begin
    next_part_en   = part_en;
    next_numgrp    = numgrp;
    next_maxgrp    = maxgrp;
    next_index_pos = index_pos;
    next_base      = base;
    next_log_addr  = log_addr;
    next_fn_en     = fn_en;
    next_upstream  = upstream;
    next_sta_pri   = sta_pri;
    next_sta_sec   = sta_sec;
    next_rcv_vec   = rcv_vec;
    next_blk_vec   = blk_vec;
    next_but_vec   = but_vec;
    next_rdata     = '0;                    // unmapped addresses read zero
    if (REG_WR) begin
      unique case (REG_ADDR)
        OFS_PART_CTL: begin
          next_part_en = REG_WDATA[POS_PART_EN];
          next_numgrp  = REG_WDATA[POS_NUMGRP +: 6];
        end
        OFS_CAP:      next_maxgrp    = REG_WDATA[POS_MAXGRP +: 6];
        OFS_BASE_LO: begin
          next_index_pos           = REG_WDATA[POS_INDEX +: 6];
          next_base[31:POS_BASE_LO] = REG_WDATA[31:POS_BASE_LO];
        end
        OFS_BASE_HI:  next_base[63:32] = REG_WDATA;
        default: begin
          if (port_hit) begin
            unique case (port_ofs)
              OFS_P_CTL: begin
                next_fn_en[port_sel]    = REG_WDATA[POS_FN_EN];
                next_upstream[port_sel] = REG_WDATA[POS_UPSTREAM];
              end
              OFS_P_RCV_LO: next_rcv_vec[port_sel][31:0]  = REG_WDATA;
              OFS_P_RCV_HI: next_rcv_vec[port_sel][63:32] = REG_WDATA;
              OFS_P_BLK_LO: next_blk_vec[port_sel][31:0]  = REG_WDATA;
              OFS_P_BLK_HI: next_blk_vec[port_sel][63:32] = REG_WDATA;
              OFS_P_BUT_LO: next_but_vec[port_sel][31:0]  = REG_WDATA;
              OFS_P_BUT_HI: next_but_vec[port_sel][63:32] = REG_WDATA;
              OFS_P_STS: begin
                // write one to clear
                if (REG_WDATA[POS_STA_PRI]) next_sta_pri[port_sel] = 1'b0;
                if (REG_WDATA[POS_STA_SEC]) next_sta_sec[port_sel] = 1'b0;
              end
              default: ;
            endcase
          end
        end
      endcase
    end
    // blocked packet: abort flag by port role, header address logged
    if (blk_event) begin
      if (upstream[PKT_PORT]) next_sta_pri[PKT_PORT] = 1'b1;
      else                    next_sta_sec[PKT_PORT] = 1'b1;
      next_log_addr = PKT_ADDR;
    end
    if (REG_RD) begin
      unique case (REG_ADDR)
        OFS_PART_CTL: begin
          next_rdata[POS_PART_EN]     = part_en;
          next_rdata[POS_NUMGRP +: 6] = numgrp;
        end
        OFS_CAP:      next_rdata[POS_MAXGRP +: 6] = maxgrp;
        OFS_BASE_LO:  next_rdata = {base[31:POS_BASE_LO], 6'h0, index_pos};
        OFS_BASE_HI:  next_rdata = base[63:32];
        OFS_LOG_LO:   next_rdata = log_addr[31:0];
        OFS_LOG_HI:   next_rdata = log_addr[63:32];
        default: begin
          if (port_hit) begin
            unique case (port_ofs)
              OFS_P_CTL: begin
                next_rdata[POS_FN_EN]    = fn_en[port_sel];
                next_rdata[POS_UPSTREAM] = upstream[port_sel];
              end
              OFS_P_RCV_LO: next_rdata = rcv_vec[port_sel][31:0];
              OFS_P_RCV_HI: next_rdata = rcv_vec[port_sel][63:32];
              OFS_P_BLK_LO: next_rdata = blk_vec[port_sel][31:0];
              OFS_P_BLK_HI: next_rdata = blk_vec[port_sel][63:32];
              OFS_P_BUT_LO: next_rdata = but_vec[port_sel][31:0];
              OFS_P_BUT_HI: next_rdata = but_vec[port_sel][63:32];
              OFS_P_STS: begin
                next_rdata[POS_STA_PRI] = sta_pri[port_sel];
                next_rdata[POS_STA_SEC] = sta_sec[port_sel];
              end
              default: ;
            endcase
          end
        end
      endcase
    end
  end

  // register storage; software must quiesce traffic before retuning
  always_ff @(posedge SYS_CLK or negedge RESETN) begin
    if (!RESETN) begin
      part_en   <= 1'b0;
      numgrp    <= 6'h0;
      maxgrp    <= RST_MAXGRP;
      index_pos <= 6'h0;
      base      <= 64'h0;
      log_addr  <= 64'h0;
      fn_en     <= '0;
      upstream  <= '0;
      sta_pri   <= '0;
      sta_sec   <= '0;
      rdata     <= '0;
      for (int p = 0; p < NUM_PORTS; p++) begin
        rcv_vec[p] <= 64'h0;
        blk_vec[p] <= 64'h0;
        but_vec[p] <= 64'h0;
      end
    end else begin
      part_en   <= next_part_en;
      numgrp    <= next_numgrp;
      maxgrp    <= next_maxgrp;
      index_pos <= next_index_pos;
      base      <= next_base;
      log_addr  <= next_log_addr;
      fn_en     <= next_fn_en;
      upstream  <= next_upstream;
      sta_pri   <= next_sta_pri;
      sta_sec   <= next_sta_sec;
      rdata     <= next_rdata;
      rcv_vec   <= next_rcv_vec;
      blk_vec   <= next_blk_vec;
      but_vec   <= next_but_vec;
    end
  end

endmodule

// ==== bench/mc_router_chk_assertions.sv ====
// Purpose: port checks on mc_router results
// Assumes: one clock, RESETN low clears all results
// Notes  : watches header inputs and result outputs
`timescale 1ns/1ps
module mc_router_chk #(parameter int NUM_PORTS = 16) (
  input wire logic                           SYS_CLK, RESETN, PKT_VALID, PKT_ERR,
  input wire mc_router_pkg::pkt_kind_t       PKT_KIND,
  input wire logic [$clog2(NUM_PORTS)-1:0]   PKT_PORT,
  input wire logic [NUM_PORTS-1:0]           RES_ACCEPT,
  input wire logic [5:0]                     RES_GROUP,
  input wire logic RES_VALID, RES_UNICAST, RES_MULTICAST, RES_DISCARD, RES_BLOCKED,
  input wire logic RES_CREDIT_RETURN, RES_AER_MC_BLOCKED, RES_PASS_ERR
);
  import mc_router_pkg::*;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!RESETN);
  a_result_pulse: assert property (PKT_VALID |=> RES_VALID)
    else $error("header without result");
  a_no_spurious: assert property (!PKT_VALID |=> !RES_VALID && RES_ACCEPT == '0)
    else $error("result without header");
  a_kind_filter: assert property (PKT_VALID && !PKT_ERR && PKT_KIND == KIND_OTHER
    |=> RES_UNICAST && !RES_MULTICAST) else $error("other kind classified multicast");
  a_err_passes: assert property (PKT_VALID && PKT_ERR |=> RES_PASS_ERR && !RES_MULTICAST)
    else $error("bad header classified");
  a_block_credit: assert property (RES_CREDIT_RETURN == RES_BLOCKED
    && RES_AER_MC_BLOCKED == RES_BLOCKED) else $error("blocked side effects differ");
  a_discard_quiet: assert property (RES_DISCARD |-> RES_ACCEPT == '0 && !RES_BLOCKED)
    else $error("discard with acceptor or error");
  a_self_ignore: assert property (PKT_VALID |=> !RES_ACCEPT[$past(PKT_PORT)])
    else $error("ingress function accepted own packet");
  a_group_clear: assert property (!RES_MULTICAST |-> RES_GROUP == 6'h00)
    else $error("group without multicast");
  c_blocked: cover property (RES_BLOCKED);
  c_discard: cover property (RES_DISCARD);
  c_accept: cover property (RES_ACCEPT != '0);
endmodule
bind mc_router mc_router_chk #(.NUM_PORTS(NUM_PORTS)) u_mc_router_chk (.*);

// ==== bench/link_partner_model.sv ====
// Purpose: link partner offering one header per send call
// Assumes: headers change just after a rising edge
// Notes  : a released address shows the inverted last value, never a stale copy
`timescale 1ns/1ps
module link_partner_model #(parameter int NUM_PORTS = 4) (
  input  wire logic                     SYS_CLK,
  output logic                          PKT_VALID,
  output mc_router_pkg::pkt_kind_t      PKT_KIND,
  output logic [63:0]                   PKT_ADDR,
  output logic [1:0]                    PKT_AT,
  output logic [$clog2(NUM_PORTS)-1:0]  PKT_PORT,
  output logic                          PKT_ERR,
  output logic                          PKT_ACS_FAIL
);
  import mc_router_pkg::*;
  initial {PKT_VALID, PKT_KIND, PKT_ADDR, PKT_AT, PKT_PORT, PKT_ERR, PKT_ACS_FAIL} = '0;
  // header stands for exactly one sampling edge, then valid drops and address and type invert
  task automatic send(pkt_kind_t k, logic [63:0] a, logic [1:0] t, int p, logic e, logic c);
    @(posedge SYS_CLK);
    {PKT_VALID, PKT_KIND, PKT_ADDR, PKT_AT} <= {1'b1, k, a, t};
    {PKT_PORT, PKT_ERR, PKT_ACS_FAIL} <= {p[$clog2(NUM_PORTS)-1:0], e, c};
    @(posedge SYS_CLK);
    {PKT_VALID, PKT_ADDR, PKT_AT} <= {1'b0, ~a, ~t};
  endtask
endmodule

// ==== bench/mc_router_tb.sv ====
// Purpose: random and corner traffic through mc_router
// Assumes: four ports, headers come from the link partner model
// Notes  : expectations rebuilt here from the programmed setup
`timescale 1ns/1ps
module mc_router_tb;
  import mc_router_pkg::*;
  localparam int NP = 4;  // few ports keep the run short
  logic SYS_CLK, RESETN, REG_WR, REG_RD, PKT_VALID, PKT_ERR, PKT_ACS_FAIL, en;
  logic [11:0] REG_ADDR;
  logic [31:0] REG_WDATA, REG_RDATA, lastlo;
  pkt_kind_t PKT_KIND;
  logic [63:0] PKT_ADDR, base, v, rcv[NP], blk[NP], but[NP];
  logic [1:0] PKT_AT, PKT_PORT, sts[NP];
  logic [NP-1:0] fe, up, RES_ACCEPT;
  logic [5:0] RES_GROUP;
  logic RES_VALID, RES_UNICAST, RES_MULTICAST, RES_DISCARD, RES_ACS_FAIL, RES_BLOCKED;
  logic RES_CREDIT_RETURN, RES_AER_MC_BLOCKED, RES_PASS_ERR;
  int ix, ng, error_cnt, n_checks;
  mc_router #(.NUM_PORTS(NP)) u_mc_router (.*);
  link_partner_model #(.NUM_PORTS(NP)) u_link_partner_model (.*);
  initial begin
    SYS_CLK = 1'b0;
    forever #12.5 SYS_CLK = ~SYS_CLK;
  end
  task automatic chk(logic [31:0] g, logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    @(posedge SYS_CLK);
    {REG_WR, REG_ADDR, REG_WDATA} <= {1'b1, a, d};
    @(posedge SYS_CLK);
    REG_WR <= 1'b0;
  endtask
  task automatic rdc(logic [11:0] a, logic [31:0] e);
    @(posedge SYS_CLK);
    {REG_RD, REG_ADDR} <= {1'b1, a};
    @(posedge SYS_CLK);
    REG_RD <= 1'b0;
    #1 chk(REG_RDATA, e);
    // read data stands one cycle only, then the port returns to zero
    @(posedge SYS_CLK);
    #1 chk(REG_RDATA, 32'h0);
  endtask
  // packed result: credit, aer, valid, accept set, group, mc, uni, blocked, discard, acs, pass
  function automatic logic [31:0] exp_res(int k, logic [63:0] a, logic [1:0] t, int p,
                                          logic er, logic ac);
    int gw, g;
    logic [NP-1:0] acc;
    gw = $clog2(ng + 1);
    g = int'((a >> ix) & ((64'h1 << gw) - 64'h1));
    if (er) return 32'h10001;
    if (!en || k == 2 || (a & ~((64'h1 << (ix + gw)) - 64'h1)) != base || g > ng)
      return 32'h10010;
    if (ac) return {16'h1, 4'h0, g[5:0], 6'h22};
    if (blk[p][g] || (but[p][g] && t == AT_UNTRANSLATED)) return {16'h7, 4'h0, g[5:0], 6'h28};
    for (int q = 0; q < NP; q++) acc[q] = q != p && fe[q] && rcv[q][g];
    return {16'h1, acc, g[5:0], 3'h4, acc == '0, 2'h0};
  endfunction
  task automatic send_chk(int k, logic [63:0] a, logic [1:0] t, int p, logic er, logic ac);
    logic [31:0] e, g;
    e = exp_res(k, a, t, p, er, ac);
    u_link_partner_model.send(pkt_kind_t'(k), a, t, p, er, ac);
    #1 g = {13'h0, RES_CREDIT_RETURN, RES_AER_MC_BLOCKED, RES_VALID, RES_ACCEPT, RES_GROUP,
            RES_MULTICAST, RES_UNICAST, RES_BLOCKED, RES_DISCARD, RES_ACS_FAIL, RES_PASS_ERR};
    chk(g, e);
    if (e[3]) sts[p] |= up[p] ? 2'h1 : 2'h2;
    if (e[3]) lastlo = a[31:0];
  endtask
  initial begin
    void'($urandom(8));
    {REG_WR, REG_RD, REG_ADDR, REG_WDATA, RESETN, lastlo, error_cnt, n_checks} = '0;
    {ix, ng, en, fe, up} = {12 + $urandom % 8, int'($urandom % 6), 1'b1, 8'($urandom)};
    base = {$urandom, $urandom} & ~((64'h1 << (ix + 3)) - 64'h1);
    for (int i = 0; i < NP; i++) begin
      // block-all bits sit in the low word so the low groups really get blocked
      {rcv[i], blk[i], sts[i]} = {$urandom, $urandom, 32'h0, $urandom & $urandom, 2'h0};
      but[i] = {$urandom & $urandom, $urandom & $urandom};
    end
    repeat (20) @(posedge SYS_CLK);
    RESETN <= 1'b1;
    rdc(OFS_CAP, {26'h0, RST_MAXGRP});
    rdc(12'h020, 32'h0);
    wr(OFS_PART_CTL, {18'h0, ng[5:0], 8'h1});
    wr(OFS_BASE_LO, {base[31:12], 6'h0, ix[5:0]});
    wr(OFS_BASE_HI, base[63:32]);
    for (int i = 0; i < NP; i++) begin
      wr(OFS_PORT_BASE + 12'(i * 32), {30'h0, up[i], fe[i]});
      for (int j = 0; j < 6; j++) begin
        v = j < 2 ? rcv[i] : j < 4 ? blk[i] : but[i];
        wr(OFS_PORT_BASE + 12'(i * 32 + j * 4 + 4), j[0] ? v[63:32] : v[31:0]);
      end
    end
    send_chk(0, base | (64'(ng + 1) << ix), 2'h0, 0, 1'b0, 1'b0);
    repeat (150) send_chk($urandom % 3, ($urandom % 6 == 0) ? {$urandom, $urandom} :
      base | (64'($urandom % 8) << ix) | (64'($urandom) & ((64'h1 << ix) - 64'h1)),
      2'($urandom), $urandom % NP, $urandom % 10 == 0, $urandom % 10 == 0);
    // abort flags: read what traffic set, clear by writing ones, read back zero
    for (int i = 0; i < NP; i++) begin
      rdc(OFS_PORT_BASE + 12'(i * 32 + 28), {30'h0, sts[i]});
      wr(OFS_PORT_BASE + 12'(i * 32 + 28), 32'h3);
      rdc(OFS_PORT_BASE + 12'(i * 32 + 28), 32'h0);
    end
    rdc(OFS_LOG_LO, lastlo);
    $display("test traffic done");
    wr(OFS_PART_CTL, 32'h0);
    en = 1'b0;
    send_chk(0, base, 2'h0, 1, 1'b0, 1'b0);
    $display("test disable done");
    test_done;
  end
  // watchdog sized well above the few hundred cycles the tests need
  initial begin
    #(25 * 5000);
    error_cnt++;
    test_done;
  end
  task automatic test_done;
    $display("checks=%0d errors=%0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
endmodule
